// ### logic/fpraf_core.sv
// Floating point register array with format aware read and write, the
// exception check on the control/status register and condition flags.
// Assumes one synchronous requester; all results are registered.
//
// How it works
// - Untyped word and doubleword formats behave as word and doubleword.
// - A paired doubleword access to an odd register does nothing harmful.
// - A paired doubleword write puts the low half in the named register.
// - A paired doubleword write puts the high half in the next register.
// - A paired doubleword read joins next register low over named low.
// - Long is ignored in paired mode; otherwise 64 bits move whole.
// - Data is only meaningful when read back in the format it was written.
// - Unimplemented-operation cause bit 17 always raises the exception.
// - Any cause bit 16..12 with its enable bit 11..7 raises the exception.
// - Flag 0 reads bit 23, flag n reads bit 24 plus n.
// - A flag write changes only the selected flag.
`timescale 1ns/1ps
`include "fpraf_params.svh"
module fpraf_core (
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       paired_register_mode_in,
    input  wire fpraf_pkg::fpraf_access_t   fp_register_write_in,
    input  wire fpraf_pkg::fpraf_access_t   fp_register_read_in,
    input  wire logic                       csr_write_in,
    input  wire logic [`FPRAF_CSR_W-1:0]    csr_write_data_in,
    input  wire fpraf_pkg::fpraf_flag_t     cond_flag_write_in,
    input  wire logic [`FPRAF_CC_W-1:0]     cond_flag_index_in,
    output logic [`FPRAF_DATA_W-1:0]        read_data_out,
    output logic                            read_valid_out,
    output logic                            read_unpredictable_out,
    output logic                            fp_exception_check_out,
    output logic                            cond_flag_read_out,
    output logic [`FPRAF_CSR_W-1:0]         fp_control_status_reg_out
);
    logic [`FPRAF_DATA_W-1:0] fpr [`FPRAF_NUM_REGS];
    logic [`FPRAF_CSR_W-1:0]  next_csr;
    logic [`FPRAF_IDX_W-1:0]  wr_pair;
    logic [`FPRAF_IDX_W-1:0]  rd_pair;
    logic                     wr_dbl;
    logic                     rd_dbl;
    logic [`FPRAF_HALF_W-1:0] wr_lo;
    logic [`FPRAF_HALF_W-1:0] wr_hi;
    logic [`FPRAF_HALF_W-1:0] rd_lo;
    logic [`FPRAF_HALF_W-1:0] rd_hi;
    logic [`FPRAF_CAUSE_HI-`FPRAF_CAUSE_LO:0] cause_bits;
    logic [`FPRAF_CAUSE_HI-`FPRAF_CAUSE_LO:0] enable_bits;

    // Bit position of a condition flag in the control/status register.
    function automatic logic [4:0] flag_pos(input logic [2:0] idx);
        if (idx == 3'h0)
        begin
            flag_pos = 5'(`FPRAF_CC0_BIT);
        end
        else
        begin
            flag_pos = 5'(`FPRAF_CCN_BASE) + {2'h0, idx};
        end
    endfunction

    assign wr_dbl = (fp_register_write_in.fmt == fpraf_pkg::FPRAF_FMT_D) ||
                    (fp_register_write_in.fmt == fpraf_pkg::FPRAF_FMT_UDWORD);
    assign rd_dbl = (fp_register_read_in.fmt == fpraf_pkg::FPRAF_FMT_D) ||
                    (fp_register_read_in.fmt == fpraf_pkg::FPRAF_FMT_UDWORD);
    assign wr_pair = fp_register_write_in.index + 5'h01;
    assign rd_pair = fp_register_read_in.index + 5'h01;
    assign wr_lo = fp_register_write_in.value[`FPRAF_HALF_W-1:0];
    assign wr_hi = fp_register_write_in.value[`FPRAF_DATA_W-1:`FPRAF_HALF_W];
    assign rd_lo = fpr[fp_register_read_in.index][`FPRAF_HALF_W-1:0];
    assign rd_hi = fpr[rd_pair][`FPRAF_HALF_W-1:0];
    assign cause_bits =
        fp_control_status_reg_out[`FPRAF_CAUSE_HI:`FPRAF_CAUSE_LO];
    assign enable_bits =
        fp_control_status_reg_out[`FPRAF_ENABLE_HI:`FPRAF_ENABLE_LO];

    // Register array writes; all paths complete in one cycle.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < `FPRAF_NUM_REGS; i++)
            begin
                fpr[i] <= `FPRAF_REG_RESET;
            end
        end
        else if (fp_register_write_in.valid)
        begin
            case (fp_register_write_in.fmt)
                fpraf_pkg::FPRAF_FMT_S,
                fpraf_pkg::FPRAF_FMT_W,
                fpraf_pkg::FPRAF_FMT_UWORD:
                begin
                    fpr[fp_register_write_in.index] <=
                        fp_register_write_in.value;
                end
                fpraf_pkg::FPRAF_FMT_D,
                fpraf_pkg::FPRAF_FMT_UDWORD:
                begin
                    if (!paired_register_mode_in)
                    begin
                        if (!fp_register_write_in.index[0])
                        begin
                            fpr[fp_register_write_in.index] <=
                                {`FPRAF_HALF_ZERO, wr_lo};
                            fpr[wr_pair] <=
                                {`FPRAF_HALF_ZERO, wr_hi};
                        end
                    end
                    else
                    begin
                        fpr[fp_register_write_in.index] <=
                            fp_register_write_in.value;
                    end
                end
                fpraf_pkg::FPRAF_FMT_L:
                begin
                    if (paired_register_mode_in)
                    begin
                        fpr[fp_register_write_in.index] <=
                            fp_register_write_in.value;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // Register array reads, answered one cycle after the request.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            read_data_out          <= `FPRAF_REG_RESET;
            read_valid_out         <= 1'b0;
            read_unpredictable_out <= 1'b0;
        end
        else
        begin
            read_valid_out         <= fp_register_read_in.valid;
            read_unpredictable_out <= 1'b0;
            if (fp_register_read_in.valid)
            begin
                if (rd_dbl && !paired_register_mode_in)
                begin
                    // odd register read flagged, returns zero
                    if (fp_register_read_in.index[0])
                    begin
                        read_data_out          <= `FPRAF_REG_RESET;
                        read_unpredictable_out <= 1'b1;
                    end
                    else
                    begin
                        read_data_out <= {rd_hi, rd_lo};
                    end
                end
                else if (fp_register_read_in.fmt == fpraf_pkg::FPRAF_FMT_L
                         && !paired_register_mode_in)
                begin
                    // long read in paired mode is unpredictable
                    read_data_out          <= `FPRAF_REG_RESET;
                    read_unpredictable_out <= 1'b1;
                end
                else
                begin
                    read_data_out <= fpr[fp_register_read_in.index];
                end
            end
        end
    end

    // Flag write overlays a software write of the whole register.
    always_comb
    begin
        next_csr = fp_control_status_reg_out;
        if (csr_write_in)
        begin
            next_csr = csr_write_data_in;
        end
        if (cond_flag_write_in.valid)
        begin
            next_csr[flag_pos(cond_flag_write_in.index)] =
                cond_flag_write_in.value;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fp_control_status_reg_out <= `FPRAF_CSR_RESET;
        end
        else
        begin
            fp_control_status_reg_out <= next_csr;
        end
    end

    // Exception check and flag read follow the stored register by a cycle.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fp_exception_check_out <= 1'b0;
            cond_flag_read_out     <= 1'b0;
        end
        else
        begin
            fp_exception_check_out <=
                fp_control_status_reg_out[`FPRAF_CSR_UNIMPL] ||
                (|(cause_bits & enable_bits));
            cond_flag_read_out <=
                fp_control_status_reg_out[flag_pos(cond_flag_index_in)];
        end
    end
endmodule // fpraf_core

// ### logic/fpraf_params.svh
// Constants for the floating point register access and flag block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FPRAF_PARAMS_SVH
`define FPRAF_PARAMS_SVH
`define FPRAF_NUM_REGS      32
`define FPRAF_IDX_W         5
`define FPRAF_DATA_W        64
`define FPRAF_HALF_W        32
`define FPRAF_CSR_W         32
`define FPRAF_CSR_UNIMPL    17
`define FPRAF_CAUSE_HI      16
`define FPRAF_CAUSE_LO      12
`define FPRAF_ENABLE_HI     11
`define FPRAF_ENABLE_LO     7
`define FPRAF_CC0_BIT       23
`define FPRAF_CCN_BASE      24
`define FPRAF_CC_W          3
`define FPRAF_CSR_RESET     32'h0000_0000
`define FPRAF_REG_RESET     64'h0000_0000_0000_0000
`define FPRAF_HALF_ZERO     32'h0000_0000
`endif

// ### logic/fpraf_pkg.sv
// Types shared by the floating point register access block.
// Assumes the constants header is on the include path.
`include "fpraf_params.svh"
package fpraf_pkg;
    typedef enum logic [2:0] {
        FPRAF_FMT_S,
        FPRAF_FMT_W,
        FPRAF_FMT_UWORD,
        FPRAF_FMT_D,
        FPRAF_FMT_UDWORD,
        FPRAF_FMT_L
    } fpraf_fmt_t;

    typedef struct packed {
        logic                        valid;
        logic [`FPRAF_IDX_W-1:0]     index;
        fpraf_fmt_t                  fmt;
        logic [`FPRAF_DATA_W-1:0]    value;
    } fpraf_access_t;

    typedef struct packed {
        logic                        valid;
        logic [`FPRAF_CC_W-1:0]      index;
        logic                        value;
    } fpraf_flag_t;
endpackage

// ### verif/fpraf_core_props.sv
// Checker on the ports of the register access block.
// Assumes it is bound to every instance of fpraf_core.
`timescale 1ns/1ps
module fpraf_core_props (
    input wire logic                     clk_in,
    input wire logic                     rst_in,
    input wire logic                     paired_register_mode_in,
    input wire fpraf_pkg::fpraf_access_t fp_register_write_in,
    input wire fpraf_pkg::fpraf_access_t fp_register_read_in,
    input wire logic                     csr_write_in,
    input wire logic [31:0]              csr_write_data_in,
    input wire fpraf_pkg::fpraf_flag_t   cond_flag_write_in,
    input wire logic [2:0]               cond_flag_index_in,
    input wire logic [63:0]              read_data_out,
    input wire logic                     read_valid_out,
    input wire logic                     read_unpredictable_out,
    input wire logic                     fp_exception_check_out,
    input wire logic                     cond_flag_read_out,
    input wire logic [31:0]              fp_control_status_reg_out
);
    wire [31:0] c = fp_control_status_reg_out;
    wire fpraf_pkg::fpraf_access_t q = fp_register_read_in;
    wire fpraf_pkg::fpraf_flag_t f = cond_flag_write_in;
    wire [4:0] rpos = cond_flag_index_in == 3'h0 ? 5'h17 :
                      5'h18 + cond_flag_index_in;
    wire [4:0] wpos = f.index == 3'h0 ? 5'h17 : 5'h18 + f.index;
    wire [31:0] wm = 32'h0000_0001 << wpos;
    wire en = |(c[16:12] & c[11:7]);
    wire pdw = !paired_register_mode_in && q.valid &&
               (q.fmt == fpraf_pkg::FPRAF_FMT_D ||
                q.fmt == fpraf_pkg::FPRAF_FMT_UDWORD);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    rd_answer_a: assert property (q.valid |=> read_valid_out)
        else $error("read not answered");
    rd_idle_a: assert property (!q.valid |=> !read_valid_out)
        else $error("read answer without request");
    odd_pair_a: assert property (pdw && q.index[0] |=>
        read_unpredictable_out && read_data_out == 64'h0)
        else $error("odd paired read not refused");
    long_pair_a: assert property (!paired_register_mode_in
        && q.valid && q.fmt == fpraf_pkg::FPRAF_FMT_L
        |=> read_unpredictable_out)
        else $error("paired long read not refused");
    unimpl_exc_a: assert property (c[17] |=> fp_exception_check_out)
        else $error("unimplemented cause ignored");
    enable_exc_a: assert property (en |=> fp_exception_check_out)
        else $error("enabled cause ignored");
    quiet_exc_a: assert property (!c[17] && !en
        |=> !fp_exception_check_out)
        else $error("exception without cause");
    flag_read_a: assert property (1'b1
        |=> cond_flag_read_out == $past(c[rpos]))
        else $error("flag read from wrong bit");
    flag_write_a: assert property (f.valid && !csr_write_in
        |=> c[$past(wpos)] == $past(f.value) &&
        (c & ~$past(wm)) == ($past(c) & ~$past(wm)))
        else $error("flag write wrong");
    csr_load_a: assert property (csr_write_in && !f.valid |=>
        c == $past(csr_write_data_in))
        else $error("control register load wrong");
endmodule // fpraf_core_props
bind fpraf_core fpraf_core_props i_props (.*);

// ### verif/fpraf_requester.sv
// Model of the execution pipeline issuing requests to the block.
// Assumes its tasks are called just after a rising edge of clk_in.
`timescale 1ns/1ps
module fpraf_requester (
    input  wire logic                clk_in,
    output fpraf_pkg::fpraf_access_t wr_out,
    output fpraf_pkg::fpraf_access_t rd_out,
    output logic                     mode_out,
    output logic                     csr_we_out,
    output logic [31:0]              csr_d_out,
    output fpraf_pkg::fpraf_flag_t   fw_out,
    output logic [2:0]               fidx_out
);
    initial
    begin
        wr_out     = '0;
        rd_out     = '0;
        mode_out   = 1'b0;
        csr_we_out = 1'b0;
        csr_d_out  = 32'h0000_0000;
        fw_out     = '0;
        fidx_out   = 3'h0;
    end
    task automatic set_mode(input logic b);
        mode_out = b;
    endtask
    // Read index kept in range by its width.
    task automatic set_index(input logic [2:0] i);
        fidx_out = i;
    endtask
    task automatic wr(input logic [4:0] i, input fpraf_pkg::fpraf_fmt_t f,
                      input logic [63:0] v);
        wr_out = '{1'b1, i, f, v};
        @(posedge clk_in) #1 wr_out.valid = 1'b0;
    endtask
    task automatic rd(input logic [4:0] i, input fpraf_pkg::fpraf_fmt_t f);
        rd_out = '{1'b1, i, f, 64'h0};
        @(posedge clk_in) #1 rd_out.valid = 1'b0;
    endtask
    task automatic csr(input logic [31:0] d);
        csr_we_out = 1'b1; csr_d_out = d;
        @(posedge clk_in) #1 csr_we_out = 1'b0;
    endtask
    task automatic flag(input logic [2:0] i, input logic b);
        fw_out = '{1'b1, i, b};
        @(posedge clk_in) #1 fw_out.valid = 1'b0;
    endtask
endmodule // fpraf_requester

// ### verif/test_fp_register_access_and_flags.sv
// Self-checking bench with a behavioural model of the register file.
// Assumes the requester model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_fp_register_access_and_flags;
    logic clk_in, rst_in, mode, csr_we, rv, unp, exc, flg;
    fpraf_pkg::fpraf_access_t wr, rd;
    fpraf_pkg::fpraf_flag_t fw;
    logic [2:0] fidx;
    logic [31:0] csr_d, csr, mcsr;
    logic [63:0] rdata, mdl [32], v, e;
    logic [4:0] ix, ixo;
    logic m, dw, bad, ex;
    fpraf_pkg::fpraf_fmt_t f;
    int mismatches, n_tests, n;
    fpraf_requester i_req (.clk_in(clk_in), .wr_out(wr), .rd_out(rd),
        .mode_out(mode), .csr_we_out(csr_we), .csr_d_out(csr_d),
        .fw_out(fw), .fidx_out(fidx));
    fpraf_core i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .paired_register_mode_in(mode), .fp_register_write_in(wr),
        .fp_register_read_in(rd), .csr_write_in(csr_we),
        .csr_write_data_in(csr_d), .cond_flag_write_in(fw),
        .cond_flag_index_in(fidx), .read_data_out(rdata),
        .read_valid_out(rv), .read_unpredictable_out(unp),
        .fp_exception_check_out(exc), .cond_flag_read_out(flg),
        .fp_control_status_reg_out(csr));
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask
    task rd_chk(input logic [4:0] i, input fpraf_pkg::fpraf_fmt_t g,
                input logic [63:0] x, input logic u);
        logic [63:0] seen;
        i_req.rd(i, g);
        for (int k = 0; k < 3 && rv !== 1'b1; k++) @(posedge clk_in) #1;
        if (rv !== 1'b1)
        begin
            mismatches++;
            test_done();
        end
        seen = rdata;
        if (g <= fpraf_pkg::FPRAF_FMT_UWORD)
        begin
            seen[63:32] = 32'h0;
        end
        chk(seen, x);
        chk(unp, u);
        @(posedge clk_in) #1;
    endtask
    initial
    begin
        void'($urandom(83));
        rst_in = 1'b1;
        repeat (16) @(posedge clk_in);
        #1 rst_in = 1'b0;
        chk(rdata, '0);
        chk({rv, unp, exc, flg, csr}, '0);
        $display("test reset done");
        foreach (mdl[k])
        begin
            mdl[k] = '0;
        end
        for (n = 0; n < 300; n++)
        begin
            ix = 5'($urandom);
            m = 1'($urandom);
            v = {$urandom, $urandom};
            f = fpraf_pkg::fpraf_fmt_t'($urandom % 6);
            dw = f inside {fpraf_pkg::FPRAF_FMT_D,
                           fpraf_pkg::FPRAF_FMT_UDWORD};
            bad = !m && (f == fpraf_pkg::FPRAF_FMT_L || (dw && ix[0]));
            i_req.set_mode(m);
            i_req.wr(ix, f, v);
            if (!bad && !m && dw)
            begin
                mdl[ix + 1] = {32'h0, v[63:32]};
                mdl[ix] = {32'h0, v[31:0]};
            end
            else if (!bad)
            begin
                mdl[ix] = v;
            end
            if (bad)
                e = '0;
            else if (!m && dw)
                e = {mdl[ix + 1][31:0], mdl[ix][31:0]};
            else if (f <= fpraf_pkg::FPRAF_FMT_UWORD)
                e = {32'h0, mdl[ix][31:0]};
            else
                e = mdl[ix];
            rd_chk(ix, f, e, bad);
            ixo = ix ^ 5'h01;
            e = {32'h0, mdl[ixo][31:0]};
            rd_chk(ixo, fpraf_pkg::FPRAF_FMT_W, e, 1'b0);
        end
        $display("test register access done");
        for (n = 0; n < 60; n++)
        begin
            mcsr = n == 0 ? 32'h0002_0000 : n == 1 ? 32'h0000_1080 : $urandom;
            i_req.csr(mcsr);
            @(posedge clk_in) #1;
            ex = mcsr[17] | (|(mcsr[16:12] & mcsr[11:7]));
            chk(csr, mcsr);
            chk(exc, ex);
        end
        $display("test exception check done");
        for (n = 0; n < 16; n++)
        begin
            v[0] = 1'($urandom);
            i_req.flag(3'(n), v[0]);
            @(posedge clk_in) #1;
            mcsr[n % 8 == 0 ? 23 : 24 + n % 8] = v[0];
            chk(csr, mcsr);
        end
        for (n = 0; n < 8; n++)
        begin
            i_req.set_index(3'(n));
            @(posedge clk_in) #1;
            chk(flg, mcsr[n == 0 ? 23 : 24 + n]);
        end
        $display("test flags done");
        test_done();
    end
endmodule // test_fp_register_access_and_flags
